/* dv/crt_video_model.sv */
// video side model: measures sync, window and cursor timing per frame
// assumes the design outputs change just after the ref_clk rising edge
module crt_video_model import crt_pkg::*; (
   // clock
   input wire logic ref_clk,
   // design video outputs
   input wire crt_video_t video,
   // pen control from the bench
   input wire logic pen_req,
   output logic light_pen_strobe,
   // measurements
   output logic [15:0] line_period,
   output logic [15:0] hs_width,
   output logic [15:0] vs_width,
   output logic [15:0] frame_period,
   output logic [15:0] win_frame,
   output logic [15:0] cur_frame,
   output logic [15:0] hs_frame
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] t, hs_t, vs_t, hs_run, vs_run, win_run, cur_run, hs_cnt;
   logic hs_d, vs_d, hs_up, vs_up;

   // pen pin follows the bench request, asynchronous to the clock
   assign light_pen_strobe = pen_req;
   assign hs_up = !hs_d && video.horizontal_sync_out;
   assign vs_up = !vs_d && video.vertical_sync_out;

   initial begin
      {t, hs_t, vs_t, hs_run, vs_run, win_run, cur_run, hs_cnt} = '0;
      {line_period, hs_width, vs_width, frame_period} = '0;
      {win_frame, cur_frame, hs_frame, hs_d, vs_d} = '0;
   end

   always @(posedge ref_clk) begin
      t <= t + 16'h0001;
      hs_d <= video.horizontal_sync_out;
      vs_d <= video.vertical_sync_out;
      hs_run <= video.horizontal_sync_out ? hs_run + 16'h0001 : 16'h0000;
      vs_run <= video.vertical_sync_out ? vs_run + 16'h0001 : 16'h0000;
      if (hs_d && !video.horizontal_sync_out) hs_width <= hs_run;
      if (vs_d && !video.vertical_sync_out) vs_width <= vs_run;
      if (hs_up) begin
         line_period <= t - hs_t;
         hs_t <= t;
      end
      if (vs_up) begin
         frame_period <= t - vs_t;
         vs_t <= t;
         win_frame <= win_run;
         cur_frame <= cur_run;
         hs_frame <= hs_cnt;
         win_run <= {15'h0000, video.display_window_active};
         cur_run <= {15'h0000, video.cursor_out};
         hs_cnt <= {15'h0000, hs_up};
      end else begin
         win_run <= win_run + {15'h0000, video.display_window_active};
         cur_run <= cur_run + {15'h0000, video.cursor_out};
         hs_cnt <= hs_cnt + {15'h0000, hs_up};
      end
   end
endmodule

/* dv/tb_crt_raster_timing_controller.sv */
// self-checking bench for the raster timing controller
// assumes the package, design files and video model are compiled first
module tb_crt_raster_timing_controller import crt_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk, rst, light_pen_strobe, pen_req;
   crt_bus_req_t bus_req;
   logic [7:0] bus_rdata;
   crt_video_t video;
   logic [15:0] line_period, hs_width, vs_width, frame_period;
   logic [15:0] win_frame, cur_frame, hs_frame;
   int num_errors, n_compared;

   crt_raster_timing crt_raster_timing_i (.ref_clk(ref_clk), .rst(rst),
      .bus_req(bus_req), .bus_rdata(bus_rdata),
      .light_pen_strobe(light_pen_strobe), .video(video));
   crt_video_model crt_video_model_i (.ref_clk(ref_clk), .video(video),
      .pen_req(pen_req), .light_pen_strobe(light_pen_strobe),
      .line_period(line_period), .hs_width(hs_width), .vs_width(vs_width),
      .frame_period(frame_period), .win_frame(win_frame),
      .cur_frame(cur_frame), .hs_frame(hs_frame));

   task automatic stop_test();
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic check8(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic check16(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one access: request held over one edge, then a quiet cycle
   task automatic bus_cycle(input logic rs, input logic wr,
                            input logic [7:0] d);
      bus_req = '{chip_select: 1'b1, register_select: rs, write_en: wr,
                  read_en: !wr, wdata: d};
      @(posedge ref_clk);
      #1;
      bus_req = '0;
      @(posedge ref_clk);
      #1;
   endtask

   task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
      bus_cycle(1'b0, 1'b1, {3'h0, a});
      bus_cycle(1'b1, 1'b1, d);
   endtask

   task automatic rd_reg(input logic [4:0] a, output logic [7:0] d);
      bus_cycle(1'b0, 1'b1, {3'h0, a});
      bus_cycle(1'b1, 1'b0, 8'h00);
      d = bus_rdata;
   endtask

   function automatic logic pick(input logic sel);
      return sel ? video.display_window_active : video.vertical_sync_out;
   endfunction

   // bounded wait for a rise of the window (1) or vertical sync (0)
   task automatic wait_rise(input logic sel, input int n);
      int k;
      for (int i = 0; i < n; i++) begin
         k = 0;
         while (pick(sel) !== 1'b0 && k < 2000) begin
            @(posedge ref_clk);
            #1;
            k++;
         end
         while (pick(sel) !== 1'b1 && k < 2000) begin
            @(posedge ref_clk);
            #1;
            k++;
         end
         if (k >= 2000) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
         end
      end
   endtask

   task automatic test_registers();
      logic [7:0] d;
      wr_reg(REG_CURSOR_ADDRESS_HIGH, 8'hFF);
      wr_reg(REG_CURSOR_ADDRESS_LOW, 8'hC5);
      rd_reg(REG_CURSOR_ADDRESS_HIGH, d);
      check8(d, 8'h3F);
      rd_reg(REG_CURSOR_ADDRESS_LOW, d);
      check8(d, 8'hC5);
      for (int i = 0; i < 14; i++) begin
         rd_reg(5'(i), d);
         check8(d, 8'h00);
      end
      wr_reg(5'h12, 8'h5A);
      rd_reg(5'h12, d);
      check8(d, 8'h00);
      rd_reg(5'h1F, d);
      check8(d, 8'h00);
      rd_reg(REG_CURSOR_ADDRESS_LOW, d);
      check8(d, 8'hC5);
   endtask

   // 16 clocks a line, 2 lines a row, 20 rows plus 2 lines a frame
   task automatic test_timing();
      logic [7:0] v [14];
      v = '{8'h0F, 8'h08, 8'h0A, 8'h03, 8'h13, 8'h02, 8'h04, 8'h06,
            8'h00, 8'h01, 8'h20, 8'h01, 8'h00, 8'h00};
      for (int i = 0; i < 14; i++) wr_reg(5'(i), v[i]);
      wr_reg(REG_CURSOR_ADDRESS_HIGH, 8'h00);
      wr_reg(REG_CURSOR_ADDRESS_LOW, 8'h03);
      // restart counters on defined registers
      rst = 1'b1;
      repeat (3) @(posedge ref_clk);
      #1;
      rst = 1'b0;
      wait_rise(1'b0, 3);
      check16(line_period, 16'd16);
      check16(hs_width, 16'd3);
      check16(hs_frame, 16'd42);
      check16(vs_width, 16'd256);
      check16(frame_period, 16'd672);
      check16(win_frame, 16'd64);
      check16(cur_frame, 16'd0);
   endtask

   task automatic test_no_hsync();
      wr_reg(REG_SYNC_WIDTH, 8'h00);
      wait_rise(1'b0, 3);
      check16(hs_frame, 16'd0);
      check16(win_frame, 16'd64);
      wr_reg(REG_SYNC_WIDTH, 8'h03);
   endtask

   task automatic test_cursor();
      wr_reg(REG_CURSOR_START_LINE, 8'h00);
      wait_rise(1'b0, 3);
      check16(cur_frame, 16'd2);
      wr_reg(REG_CURSOR_ADDRESS_LOW, 8'h04);
      wr_reg(REG_CURSOR_END_LINE, 8'h00);
      wait_rise(1'b0, 3);
      check16(cur_frame, 16'd1);
   endtask

   task automatic test_blink();
      logic [15:0] n;
      wr_reg(REG_CURSOR_START_LINE, 8'h40);
      wait_rise(1'b0, 2);
      n = 16'h0000;
      for (int i = 0; i < 16; i++) begin
         wait_rise(1'b0, 1);
         n = n + cur_frame;
      end
      check16(n, 16'd8);
   endtask

   task automatic test_interlace();
      logic [15:0] p;
      wr_reg(REG_INTERLACE_MODE, 8'h01);
      wait_rise(1'b0, 3);
      p = frame_period;
      wait_rise(1'b0, 1);
      check16(p + frame_period, 16'd1344);
      check16(p > frame_period ? p - frame_period : frame_period - p,
              16'd16);
      check16(vs_width, 16'd256);
      wr_reg(REG_INTERLACE_MODE, 8'h00);
   endtask

   task automatic test_start();
      wr_reg(REG_START_ADDRESS_HIGH, 8'h01);
      wr_reg(REG_START_ADDRESS_LOW, 8'h23);
      wait_rise(1'b0, 1);
      wait_rise(1'b1, 1);
      check16({2'b00, video.refresh_address}, 16'h0123);
      wait_rise(1'b1, 1);
      check16({2'b00, video.refresh_address}, 16'h0123);
      wait_rise(1'b1, 1);
      check16({2'b00, video.refresh_address}, 16'h012B);
   endtask

   task automatic test_pen();
      logic [13:0] q [10];
      logic [7:0] h, l, l2;
      logic [15:0] exp;
      wait_rise(1'b1, 1);
      pen_req = 1'b1;
      q[0] = video.refresh_address;
      for (int i = 1; i < 10; i++) begin
         @(posedge ref_clk);
         #1;
         q[i] = video.refresh_address;
      end
      pen_req = 1'b0;
      rd_reg(REG_PEN_CAPTURE_HIGH, h);
      rd_reg(REG_PEN_CAPTURE_LOW, l);
      exp = {2'b00, q[3]};
      for (int i = 0; i < 10; i++)
         if ({h[5:0], l} === q[i]) exp = {2'b00, q[i]};
      check16({2'b00, h[5:0], l}, exp);
      check8(h & 8'hC0, 8'h00);
      wr_reg(REG_PEN_CAPTURE_LOW, ~l);
      rd_reg(REG_PEN_CAPTURE_LOW, l2);
      check8(l2, l);
   endtask

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // about 37 frames of traffic are expected; allow about twice that
   initial begin
      #500000;
      num_errors++;
      stop_test();
   end

   initial begin
      num_errors = 0;
      n_compared = 0;
      rst = 1'b1;
      bus_req = '0;
      pen_req = 1'b0;
      repeat (3) @(posedge ref_clk);
      #1;
      rst = 1'b0;
      test_registers();
      test_timing();
      test_no_hsync();
      test_cursor();
      test_blink();
      test_interlace();
      test_start();
      test_pen();
      stop_test();
   end
endmodule

/* verilog/crt_pen_sync.sv */
// light pen strobe synchroniser and rising edge detector
// assumes the strobe is asynchronous to ref_clk
module crt_pen_sync import crt_pkg::*; (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // pin side
   input wire logic pen_pin,
   // core side
   output logic pen_rise
);
   logic meta_reg;
   logic sync_reg;
   logic prev_reg;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         prev_reg <= 1'b0;
      end else begin
         meta_reg <= pen_pin;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   assign pen_rise = sync_reg & ~prev_reg;

   chk_pen_edge_once: assert property (@(posedge ref_clk) disable iff (rst)
      pen_rise |=> !pen_rise) else $error("pen edge lasted two cycles");
endmodule

/* verilog/crt_pkg.sv */
// package for the raster timing controller: register map, fields, types
// assumes a single character clock domain and a synchronous reset
package crt_pkg;

   // pointer values of the indirect register file
   localparam logic [4:0] REG_HORIZ_TOTAL = 5'h00;
   localparam logic [4:0] REG_HORIZ_DISPLAYED = 5'h01;
   localparam logic [4:0] REG_HORIZ_SYNC_POSITION = 5'h02;
   localparam logic [4:0] REG_SYNC_WIDTH = 5'h03;
   localparam logic [4:0] REG_VERT_TOTAL = 5'h04;
   localparam logic [4:0] REG_VERT_TOTAL_ADJUST = 5'h05;
   localparam logic [4:0] REG_VERT_DISPLAYED = 5'h06;
   localparam logic [4:0] REG_VERT_SYNC_POSITION = 5'h07;
   localparam logic [4:0] REG_INTERLACE_MODE = 5'h08;
   localparam logic [4:0] REG_MAX_SCAN_LINE = 5'h09;
   localparam logic [4:0] REG_CURSOR_START_LINE = 5'h0A;
   localparam logic [4:0] REG_CURSOR_END_LINE = 5'h0B;
   localparam logic [4:0] REG_START_ADDRESS_HIGH = 5'h0C;
   localparam logic [4:0] REG_START_ADDRESS_LOW = 5'h0D;
   localparam logic [4:0] REG_CURSOR_ADDRESS_HIGH = 5'h0E;
   localparam logic [4:0] REG_CURSOR_ADDRESS_LOW = 5'h0F;
   localparam logic [4:0] REG_PEN_CAPTURE_HIGH = 5'h10;
   localparam logic [4:0] REG_PEN_CAPTURE_LOW = 5'h11;
   localparam logic [4:0] REG_LAST = 5'h11;

   // field positions
   localparam int CURSOR_MODE_LSB = 5;
   localparam int ADDR_HIGH_WIDTH = 6;

   // cursor modes
   localparam logic [1:0] CUR_STEADY = 2'h0;
   localparam logic [1:0] CUR_HIDDEN = 2'h1;
   localparam logic [1:0] CUR_BLINK16 = 2'h2;
   localparam logic [1:0] CUR_BLINK32 = 2'h3;

   // interlace modes (low two bits)
   localparam logic [1:0] ILM_SYNC = 2'h1;
   localparam logic [1:0] ILM_SYNC_VIDEO = 2'h3;

   // fixed vertical sync length in scan lines
   localparam logic [4:0] VSYNC_LINES = 5'h10;

   // reset values of counters and registers
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [13:0] RESET_ADDR = 14'h0000;

   // processor access
   typedef struct packed {
      logic chip_select;
      logic register_select;
      logic write_en;
      logic read_en;
      logic [7:0] wdata;
   } crt_bus_req_t;

   // video side outputs
   typedef struct packed {
      logic horizontal_sync_out;
      logic vertical_sync_out;
      logic display_window_active;
      logic cursor_out;
      logic [13:0] refresh_address;
      logic [4:0] scanline_row_index;
   } crt_video_t;

endpackage

/* verilog/crt_raster_timing.sv */
// raster timing controller: indirect register file, counters, syncs
// assumes one character clock; bus strobes are synchronous to it
// Contract
// (RULE1) select low writes the pointer; select high reaches the named register
// (RULE2) pointer 0 to 17 selects registers in order; above 17 selects none
// (RULE3) line period is horizontal total plus one character clocks
// (RULE4) displayed characters per line; total kept above it by software
// (RULE5) software keeps sync position past displayed, sync end below total
// (RULE6) horizontal sync begins at the sync position count
// (RULE7) sync width low nibble sets pulse length; zero gives no pulse
// (RULE8) vertical sync lasts exactly sixteen scan lines
// (RULE9) vertical total rows plus one, then adjust scan lines
// (RULE10) displayed rows count; software keeps it under vertical total
// (RULE11) vertical sync starts at the sync row position
// (RULE12) interlace bits: 00/10 normal, 01 sync, 11 sync and video
// (RULE13) interlace alternates fields; odd field sync delayed half a line
// (RULE14) sync video mode shows even lines in even field, odd in odd
// (RULE15) software programs odd totals and halves rows for interlace
// (RULE16) cursor line parity picks field; end above max gives full block
// (RULE17) row index wraps after the maximum scan line value
// (RULE18) cursor mode bits: steady, hidden, blink sixteen, blink thirty-two
// (RULE19) cursor end line gives last cursor scan line
// (RULE20) cursor address pair readable; cursor when refresh address matches
// (RULE21) start address is the first refresh address of a frame
// (RULE22) pen strobe rising edge latches the refresh address
// (RULE23) display window off from displayed count to horizontal total
// (RULE24) same addresses repeat on each scan line of a row
// (RULE25) window only when column and row are both inside display
module crt_raster_timing import crt_pkg::*; (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // processor port
   input wire crt_bus_req_t bus_req,
   output logic [7:0] bus_rdata,
   // light pen pin
   input wire logic light_pen_strobe,
   // video side
   output crt_video_t video
);
   logic [4:0] index_pointer_reg;
   logic [7:0] horiz_total_reg;
   logic [7:0] horiz_displayed_reg;
   logic [7:0] horiz_sync_position_reg;
   logic [7:0] sync_width_reg;
   logic [6:0] vert_total_reg;
   logic [4:0] vert_total_adjust_reg;
   logic [6:0] vert_displayed_reg;
   logic [6:0] vert_sync_position_reg;
   logic [5:0] interlace_mode_reg;
   logic [4:0] max_scan_line_reg;
   logic [6:0] cursor_start_line_reg;
   logic [4:0] cursor_end_line_reg;
   logic [13:0] start_address_reg;
   logic [13:0] cursor_address_reg;
   logic [13:0] pen_capture_reg;

   logic [7:0] hcount_reg;
   logic [4:0] line_reg;
   logic [6:0] row_reg;
   logic [4:0] adj_reg;
   logic in_adjust_reg;
   logic [13:0] row_base_reg;
   logic [13:0] addr_reg;
   logic [3:0] hsync_cnt_reg;
   logic [4:0] vsync_cnt_reg;
   logic vsync_pend_reg;
   logic odd_field_reg;
   logic [4:0] blink_reg;
   logic hsync_reg;
   logic de_reg;
   logic cursor_reg;
   logic [4:0] ra_reg;
   logic [13:0] ma_reg;

   logic access;
   logic [4:0] lines_max;
   logic line_end;
   logic row_end;
   logic frame_end;
   logic interlaced;
   logic vid_mode;
   logic [4:0] line_next;
   logic pen_rise;
   logic half_line;

   function automatic logic reg_write(input crt_bus_req_t r,
                                      input logic [4:0] ptr,
                                      input logic [4:0] which);
      reg_write = r.chip_select & r.register_select & r.write_en &
                  (ptr == which);
   endfunction

   assign access = bus_req.chip_select & bus_req.register_select;
   assign interlaced = interlace_mode_reg[0]; // RULE12
   assign vid_mode = interlace_mode_reg[1:0] == ILM_SYNC_VIDEO; // RULE12
   // sync video mode steps two lines at a time
   assign lines_max = max_scan_line_reg;

   // pointer write
   always_ff @(posedge ref_clk) begin
      if (bus_req.chip_select & ~bus_req.register_select &
          bus_req.write_en) begin
         index_pointer_reg <= bus_req.wdata[4:0]; // RULE1
      end
   end

   // register file writes; control registers survive reset
   always_ff @(posedge ref_clk) begin
      if (reg_write(bus_req, index_pointer_reg, REG_HORIZ_TOTAL))
         horiz_total_reg <= bus_req.wdata; // RULE2
      if (reg_write(bus_req, index_pointer_reg, REG_HORIZ_DISPLAYED))
         horiz_displayed_reg <= bus_req.wdata; // RULE4
      if (reg_write(bus_req, index_pointer_reg, REG_HORIZ_SYNC_POSITION))
         horiz_sync_position_reg <= bus_req.wdata;
      if (reg_write(bus_req, index_pointer_reg, REG_SYNC_WIDTH))
         sync_width_reg <= bus_req.wdata;
      if (reg_write(bus_req, index_pointer_reg, REG_VERT_TOTAL))
         vert_total_reg <= bus_req.wdata[6:0];
      if (reg_write(bus_req, index_pointer_reg, REG_VERT_TOTAL_ADJUST))
         vert_total_adjust_reg <= bus_req.wdata[4:0];
      if (reg_write(bus_req, index_pointer_reg, REG_VERT_DISPLAYED))
         vert_displayed_reg <= bus_req.wdata[6:0]; // RULE10
      if (reg_write(bus_req, index_pointer_reg, REG_VERT_SYNC_POSITION))
         vert_sync_position_reg <= bus_req.wdata[6:0];
      if (reg_write(bus_req, index_pointer_reg, REG_INTERLACE_MODE))
         interlace_mode_reg <= bus_req.wdata[5:0];
      if (reg_write(bus_req, index_pointer_reg, REG_MAX_SCAN_LINE))
         max_scan_line_reg <= bus_req.wdata[4:0];
      if (reg_write(bus_req, index_pointer_reg, REG_CURSOR_START_LINE))
         cursor_start_line_reg <= bus_req.wdata[6:0];
      if (reg_write(bus_req, index_pointer_reg, REG_CURSOR_END_LINE))
         cursor_end_line_reg <= bus_req.wdata[4:0];
      if (reg_write(bus_req, index_pointer_reg, REG_START_ADDRESS_HIGH))
         start_address_reg[13:8] <= bus_req.wdata[5:0];
      if (reg_write(bus_req, index_pointer_reg, REG_START_ADDRESS_LOW))
         start_address_reg[7:0] <= bus_req.wdata;
      if (reg_write(bus_req, index_pointer_reg, REG_CURSOR_ADDRESS_HIGH))
         cursor_address_reg[13:8] <= bus_req.wdata[5:0]; // RULE20
      if (reg_write(bus_req, index_pointer_reg, REG_CURSOR_ADDRESS_LOW))
         cursor_address_reg[7:0] <= bus_req.wdata;
   end

   // read mux: only cursor and pen pairs read back; others read zero
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         bus_rdata <= RESET_BYTE;
      end else if (access & bus_req.read_en) begin
         case (index_pointer_reg) // RULE2
            REG_CURSOR_ADDRESS_HIGH:
               bus_rdata <= {2'h0, cursor_address_reg[13:8]}; // RULE20
            REG_CURSOR_ADDRESS_LOW: bus_rdata <= cursor_address_reg[7:0];
            REG_PEN_CAPTURE_HIGH:
               bus_rdata <= {2'h0, pen_capture_reg[13:8]}; // RULE22
            REG_PEN_CAPTURE_LOW: bus_rdata <= pen_capture_reg[7:0];
            default: bus_rdata <= RESET_BYTE;
         endcase
      end
   end

   // light pen capture
   crt_pen_sync u_pen (
      .ref_clk(ref_clk),
      .rst(rst),
      .pen_pin(light_pen_strobe),
      .pen_rise(pen_rise)
   );

   always_ff @(posedge ref_clk) begin
      if (pen_rise) begin
         pen_capture_reg <= ma_reg; // RULE22
      end
   end

   // horizontal counter
   assign line_end = hcount_reg == horiz_total_reg; // RULE3
   assign half_line =
      hcount_reg == {1'b0, horiz_total_reg[7:1]} + 8'h01; // RULE13
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         hcount_reg <= RESET_BYTE;
      end else if (line_end) begin
         hcount_reg <= RESET_BYTE; // RULE3
      end else begin
         hcount_reg <= hcount_reg + 8'h01;
      end
   end

   // scan line and row counters
   assign line_next = vid_mode ? line_reg + 5'h02 : line_reg + 5'h01;
   assign row_end = ~in_adjust_reg &
      (vid_mode ? line_reg[4:1] >= lines_max[4:1] : line_reg == lines_max);
   assign frame_end = in_adjust_reg ? adj_reg + 5'h01 >= vert_total_adjust_reg
      : (row_end & row_reg == vert_total_reg & vert_total_adjust_reg == 5'h00);

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         line_reg <= 5'h00;
         row_reg <= 7'h00;
         adj_reg <= 5'h00;
         in_adjust_reg <= 1'b0;
         odd_field_reg <= 1'b0;
      end else if (line_end) begin
         if (frame_end) begin
            in_adjust_reg <= 1'b0;
            adj_reg <= 5'h00;
            row_reg <= 7'h00;
            odd_field_reg <= interlaced ? ~odd_field_reg : 1'b0; // RULE13
            line_reg <= (vid_mode & interlaced & ~odd_field_reg) ?
               5'h01 : 5'h00; // RULE14
         end else if (in_adjust_reg) begin
            adj_reg <= adj_reg + 5'h01; // RULE9
         end else if (row_end) begin
            line_reg <= vid_mode ? {4'h0, odd_field_reg} : 5'h00; // RULE17
            if (row_reg == vert_total_reg) begin
               in_adjust_reg <= 1'b1; // RULE9
            end else begin
               row_reg <= row_reg + 7'h01;
            end
         end else begin
            line_reg <= line_next;
         end
      end
   end

   // refresh address: row base repeats for each line of the row
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         row_base_reg <= RESET_ADDR;
         addr_reg <= RESET_ADDR;
      end else if (line_end) begin
         if (frame_end) begin
            row_base_reg <= start_address_reg; // RULE21
            addr_reg <= start_address_reg;
         end else if (row_end) begin
            row_base_reg <= row_base_reg + {6'h00, horiz_displayed_reg};
            addr_reg <= row_base_reg + {6'h00, horiz_displayed_reg};
         end else begin
            addr_reg <= row_base_reg; // RULE24
         end
      end else begin
         addr_reg <= addr_reg + 14'h0001;
      end
   end

   // horizontal sync
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         hsync_cnt_reg <= 4'h0;
         hsync_reg <= 1'b0;
      end else if (hcount_reg == horiz_sync_position_reg &
                   sync_width_reg[3:0] != 4'h0) begin
         hsync_reg <= 1'b1; // RULE6
         hsync_cnt_reg <= sync_width_reg[3:0] - 4'h1; // RULE7
      end else if (hsync_cnt_reg != 4'h0) begin
         hsync_cnt_reg <= hsync_cnt_reg - 4'h1;
      end else begin
         hsync_reg <= 1'b0;
      end
   end

   // vertical sync: starts at line start, or half a line later odd field
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         vsync_cnt_reg <= 5'h00;
         vsync_pend_reg <= 1'b0;
      end else begin
         if (line_end & row_end & ~frame_end &
             row_reg + 7'h01 == vert_sync_position_reg) begin
            vsync_pend_reg <= 1'b1; // RULE11
         end else if (vsync_pend_reg & (~odd_field_reg | half_line)) begin
            vsync_pend_reg <= 1'b0; // RULE13
         end
         if (vsync_pend_reg & (~odd_field_reg | half_line)) begin
            vsync_cnt_reg <= VSYNC_LINES; // RULE8
         end else if (vsync_cnt_reg != 5'h00 &
                      (odd_field_reg ? half_line : hcount_reg == 8'h00)) begin
            vsync_cnt_reg <= vsync_cnt_reg - 5'h01;
         end
      end
   end

   // blink divider on field rate
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         blink_reg <= 5'h00;
      end else if (line_end & frame_end) begin
         blink_reg <= blink_reg + 5'h01;
      end
   end

   // window, cursor, row index
   always_ff @(posedge ref_clk) begin
      logic cur_line;
      logic cur_en;
      logic [4:0] cs;
      cs = cursor_start_line_reg[4:0];
      cur_line = line_reg >= cs & (line_reg <= cursor_end_line_reg |
         cursor_end_line_reg > max_scan_line_reg); // RULE19 RULE16
      case (cursor_start_line_reg[6:CURSOR_MODE_LSB]) // RULE18
         CUR_STEADY: cur_en = 1'b1;
         CUR_HIDDEN: cur_en = 1'b0;
         CUR_BLINK16: cur_en = blink_reg[3];
         CUR_BLINK32: cur_en = blink_reg[4];
         default: cur_en = 1'b0;
      endcase
      if (rst) begin
         de_reg <= 1'b0;
         cursor_reg <= 1'b0;
         ra_reg <= 5'h00;
         ma_reg <= RESET_ADDR;
      end else begin
         de_reg <= hcount_reg < horiz_displayed_reg &
            row_reg < vert_displayed_reg & ~in_adjust_reg; // RULE23 RULE25
         cursor_reg <= cur_en & cur_line & ~in_adjust_reg &
            hcount_reg < horiz_displayed_reg &
            addr_reg == cursor_address_reg; // RULE20
         ra_reg <= line_reg; // RULE17
         ma_reg <= addr_reg; // RULE24
      end
   end

   assign video.horizontal_sync_out = hsync_reg;
   assign video.vertical_sync_out = vsync_cnt_reg != 5'h00;
   assign video.display_window_active = de_reg;
   assign video.cursor_out = cursor_reg;
   assign video.refresh_address = ma_reg;
   assign video.scanline_row_index = ra_reg;

   chk_hcount_wrap: assert property (@(posedge ref_clk) disable iff (rst)
      line_end |=> hcount_reg == 8'h00) // RULE3
      else $error("horizontal count did not wrap");
   chk_hsync_none: assert property (@(posedge ref_clk) disable iff (rst)
      sync_width_reg[3:0] == 4'h0 && !hsync_reg |=> !hsync_reg) // RULE7
      else $error("sync pulse with zero width");
   chk_window_blank: assert property (@(posedge ref_clk) disable iff (rst)
      hcount_reg >= horiz_displayed_reg |=> !de_reg) // RULE23
      else $error("window active in blanking");
   chk_window_rows: assert property (@(posedge ref_clk) disable iff (rst)
      row_reg >= vert_displayed_reg |=> !de_reg) // RULE25
      else $error("window active below display rows");
   chk_pointer_load: assert property (@(posedge ref_clk)
      bus_req.chip_select && !bus_req.register_select && bus_req.write_en
      |=> index_pointer_reg == $past(bus_req.wdata[4:0])) // RULE1
      else $error("pointer not loaded");
   chk_start_addr: assert property (@(posedge ref_clk) disable iff (rst)
      line_end && frame_end |=> addr_reg == $past(start_address_reg)) // RULE21
      else $error("frame did not start at start address");
   chk_row_repeat: assert property (@(posedge ref_clk) disable iff (rst)
      line_end && !row_end && !frame_end |=> addr_reg == row_base_reg) // RULE24
      else $error("line did not repeat row addresses");
   chk_pen_latch: assert property (@(posedge ref_clk) disable iff (rst)
      pen_rise |=> pen_capture_reg == $past(ma_reg)) // RULE22
      else $error("pen capture missed");
   chk_vsync_len: assert property (@(posedge ref_clk) disable iff (rst)
      vsync_pend_reg && (!odd_field_reg || half_line)
      |=> vsync_cnt_reg == VSYNC_LINES) // RULE8
      else $error("vertical sync length wrong");
endmodule
